/* File: sim/mst_target_model.sv */
// target-side model: probe activity, trigger recognisers, capture completion
`timescale 1ns/1ps
`default_nettype none
module mst_target_model #(
   parameter int PROBE_W = mst_pkg::STATE_CH_SMALL + mst_pkg::TIMING_CH + mst_pkg::POD_BITS
) (
   input wire logic clk,
   input wire logic reset_n,
   output var logic [PROBE_W-1:0] probe_in,
   output var logic state_trig_hit,
   output var logic timing_trig_hit,
   output var logic state_capture_done,
   output var logic timing_capture_done
);
   ////////////////////////////////////////////////////////////////////////////
   // probes shift one bit every cycle, so a stale copy of a narrow slice such as the timing pod can still match
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         probe_in <= '0;
      end else begin
         probe_in <= {probe_in[PROBE_W-2:0], ~probe_in[PROBE_W-1]};
      end
   end
   // recognisers and captures idle until commanded
   initial begin
      state_trig_hit = 1'b0;
      timing_trig_hit = 1'b0;
      state_capture_done = 1'b0;
      timing_capture_done = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one-cycle trigger seen by the chosen recogniser
   task automatic hit(input logic tmg);
      @(posedge clk);
      if (tmg) timing_trig_hit <= 1'b1;
      else state_trig_hit <= 1'b1;
      @(posedge clk);
      timing_trig_hit <= 1'b0;
      state_trig_hit <= 1'b0;
   endtask
   // capture completion level, after a prompt or slow lag
   task automatic done(input logic tmg, input logic lvl, input int lag);
      repeat (lag) @(posedge clk);
      if (tmg) timing_capture_done <= lvl;
      else state_capture_done <= lvl;
   endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the trigger arming block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import mst_pkg::*;
   logic clk = 1'b0;
   logic reset_n;
   logic [3:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [42:0] probe_in;
   logic state_trig_hit, timing_trig_hit, state_capture_done, timing_capture_done;
   logic state_search_en, timing_search_en, state_trig_store, timing_trig_store;
   logic [26:0] state_probe;
   logic [7:0] timing_probe;
   logic results_valid, state_data_ok, timing_data_ok, overview_en;
   mst_mode_t trace_mode;
   int failures = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [31:0] rd;
   logic [42:0] p;
   int ss, ts;
   mst_arming #(.STATE_CH(STATE_CH_SMALL), .PROBE_W(STATE_CH_SMALL + TIMING_CH + POD_BITS))
      mst_arming_i (.clk(clk), .reset_n(reset_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .probe_in(probe_in),
      .state_trig_hit(state_trig_hit), .timing_trig_hit(timing_trig_hit),
      .state_capture_done(state_capture_done), .timing_capture_done(timing_capture_done),
      .state_search_en(state_search_en), .timing_search_en(timing_search_en),
      .state_trig_store(state_trig_store), .timing_trig_store(timing_trig_store),
      .state_probe(state_probe), .timing_probe(timing_probe), .results_valid(results_valid),
      .state_data_ok(state_data_ok), .timing_data_ok(timing_data_ok),
      .trace_mode(trace_mode), .overview_en(overview_en));
   mst_target_model #(.PROBE_W(STATE_CH_SMALL + TIMING_CH + POD_BITS))
      mst_target_model_i (.clk(clk), .reset_n(reset_n),
      .probe_in(probe_in), .state_trig_hit(state_trig_hit), .timing_trig_hit(timing_trig_hit),
      .state_capture_done(state_capture_done), .timing_capture_done(timing_capture_done));
   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // compare one value
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // one bus cycle, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      if (wr) avs_write <= 1'b1;
      else avs_read <= 1'b1;
      // only the bench timeout ends a stuck wait
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // count store pulses over n cycles
   task automatic watch(input int n);
      ss = 0;
      ts = 0;
      repeat (n) begin
         @(posedge clk);
         if (state_trig_store === 1'b1) ss++;
         if (timing_trig_store === 1'b1) ts++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      reset_n <= 1'b0;
      avs_address <= 4'h0;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0000_0000;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      // static map and probe split
      bus(1'b0, OFS_CHANS, 32'h0);
      chk(rd, 32'h0000_081B, "channel split");
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      @(posedge clk);
      p = probe_in;
      @(posedge clk);
      chk(32'(timing_probe), 32'(p[42:35]), "timing probes");
      chk(32'(state_probe), 32'(p[34:8]), "state probes");
      $display("test map done");
      // state master, single mode
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk({state_search_en, timing_search_en}, 32'h2, "start search");
      mst_target_model_i.hit(1'b0);
      repeat (2) @(posedge clk);
      chk(32'(timing_search_en), 32'h1, "slave armed");
      bus(1'b0, OFS_STAT, 32'h0);
      chk(rd & 32'h0000_0202, 32'h2, "armed, no overview");
      mst_target_model_i.hit(1'b1);
      watch(4);
      chk(32'(ts), 32'h1, "slave store");
      mst_target_model_i.done(1'b0, 1'b1, 3);
      repeat (3) @(posedge clk);
      chk(32'(results_valid), 32'h0, "held until both");
      mst_target_model_i.done(1'b1, 1'b1, 0);
      repeat (3) @(posedge clk);
      chk({results_valid, state_data_ok, timing_data_ok}, 32'h7, "both done");
      mst_target_model_i.done(1'b0, 1'b0, 0);
      mst_target_model_i.done(1'b1, 1'b0, 0);
      $display("test state master done");
      // timing master, free-running slave, compare mode
      bus(1'b1, OFS_CTRL, 32'h0000_0035);
      repeat (2) @(posedge clk);
      chk(32'(trace_mode), 32'(MST_COMPARE), "common mode");
      chk({state_search_en, timing_search_en}, 32'h1, "timing master");
      bus(1'b0, OFS_CTRL, 32'h0);
      chk(rd, 32'h0000_0034, "control readback");
      bus(1'b0, OFS_STAT, 32'h0);
      chk(rd & 32'h0000_0182, 32'h0, "arming cleared");
      mst_target_model_i.hit(1'b1);
      watch(4);
      chk(32'(ss), 32'h1, "free-run store");
      bus(1'b0, OFS_STAT, 32'h0);
      chk(rd & 32'h100, 32'h100, "slave triggered");
      bus(1'b1, OFS_CTRL, 32'h0000_0036);
      @(posedge clk);
      chk({results_valid, state_data_ok, timing_data_ok}, 32'h4, "stop, none done");
      $display("test timing master done");
      // don't-care slave, continuous, then stop with slave incomplete
      bus(1'b1, OFS_CTRL, 32'h0000_0049);
      repeat (2) @(posedge clk);
      chk(32'(trace_mode), 32'(MST_CONTIN), "common mode");
      mst_target_model_i.hit(1'b0);
      watch(4);
      chk({ss[15:0], ts[15:0]}, 32'h0000_0001, "slave stores first");
      mst_target_model_i.done(1'b0, 1'b1, 2);
      repeat (3) @(posedge clk);
      bus(1'b1, OFS_CTRL, 32'h0000_0042);
      repeat (3) @(posedge clk);
      chk({results_valid, state_data_ok, timing_data_ok}, 32'h6, "stop release");
      chk(32'(overview_en), 32'h0, "no overview");
      $display("test stop done");
      // continuous mode restarts by itself after both complete
      mst_target_model_i.done(1'b0, 1'b0, 0);
      bus(1'b1, OFS_CTRL, 32'h0000_0009);
      mst_target_model_i.hit(1'b0);
      mst_target_model_i.hit(1'b1);
      mst_target_model_i.done(1'b0, 1'b1, 0);
      mst_target_model_i.done(1'b1, 1'b1, 0);
      repeat (3) @(posedge clk);
      chk({results_valid, state_data_ok, timing_data_ok}, 32'h7, "continuous both done");
      @(posedge clk);
      chk({state_search_en, timing_search_en}, 32'h2, "continuous restart");
      mst_target_model_i.done(1'b0, 1'b0, 0);
      mst_target_model_i.done(1'b1, 1'b0, 0);
      bus(1'b1, OFS_CTRL, 32'h0000_0002);
      $display("test continuous done");
      summarize();
   end
endmodule
`default_nettype wire

/* File: verilog/mst_arming.sv */
// master/slave trigger arming for combined state and timing capture
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module mst_arming #(
   parameter int STATE_CH = mst_pkg::STATE_CH_SMALL,
   parameter int PROBE_W = mst_pkg::STATE_CH_SMALL + mst_pkg::TIMING_CH + mst_pkg::POD_BITS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [PROBE_W-1:0] probe_in,
   input wire logic state_trig_hit,
   input wire logic timing_trig_hit,
   input wire logic state_capture_done,
   input wire logic timing_capture_done,
   output logic state_search_en,
   output logic timing_search_en,
   output logic state_trig_store,
   output logic timing_trig_store,
   output logic [STATE_CH-1:0] state_probe,
   output logic [mst_pkg::TIMING_CH-1:0] timing_probe,
   output logic results_valid,
   output logic state_data_ok,
   output logic timing_data_ok,
   output mst_pkg::mst_mode_t trace_mode,
   output logic overview_en
);
   import mst_pkg::*;

   ////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_q;
   logic [31:0] rdata_q;
   logic ack_q;
   logic start_p;
   logic stop_p;
   mst_seq_t seq_q;
   logic master_hit;
   logic slave_hit;
   logic master_done;
   logic slave_done;
   logic mdone_q;
   logic sdone_q;
   logic mtrig_q;
   logic strig_q;
   logic valid_q;
   logic sok_q;
   logic tok_q;
   logic s_store_q;
   logic t_store_q;
   logic [STATE_CH-1:0] sprobe_q;
   logic [TIMING_CH-1:0] tprobe_q;
   mst_master_t master;
   logic slave_freerun;
   logic slave_dontcare;
   logic [31:0] status;

   // one wait cycle per access, answer on the second
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign avs_readdata = rdata_q;

   // access acknowledge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
      end
   end

   // control register; run and stop are self-clearing pulses
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= CTRL_RESET;
      end else if (avs_write && ack_q && avs_address == OFS_CTRL) begin
         ctrl_q <= avs_writedata & 32'h0000_007C;
      end
   end

   assign start_p = avs_write & ack_q & (avs_address == OFS_CTRL) & avs_writedata[CTRL_RUN];
   assign stop_p = avs_write & ack_q & (avs_address == OFS_CTRL) & avs_writedata[CTRL_STOP];

   // a single bit selects the master, so only one can hold it
   assign master = mst_master_t'(ctrl_q[CTRL_MASTER]);
   assign trace_mode = mst_mode_t'(ctrl_q[CTRL_MODE_LO+1:CTRL_MODE_LO]);
   assign slave_freerun = ctrl_q[CTRL_FREERUN];
   assign slave_dontcare = ctrl_q[CTRL_SDELAY0];
   assign overview_en = 1'b0;

   // route trigger and completion by master role
   assign master_hit = (master == MST_STATE) ? state_trig_hit : timing_trig_hit;
   assign slave_hit = (master == MST_STATE) ? timing_trig_hit : state_trig_hit;
   assign master_done = (master == MST_STATE) ? state_capture_done : timing_capture_done;
   assign slave_done = (master == MST_STATE) ? timing_capture_done : state_capture_done;

   ////////////////////////////////////////////////////////////////////
   // trace sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         seq_q <= MST_IDLE;
      end else begin
         case (seq_q)
            MST_IDLE: begin
               if (start_p) begin
                  seq_q <= MST_MSEARCH;
               end
            end
            MST_MSEARCH: begin
               if (stop_p) begin
                  seq_q <= MST_DONE;
               end else if (master_hit) begin
                  seq_q <= MST_ARMED;
               end
            end
            MST_ARMED: begin
               if (stop_p || (mdone_q && sdone_q)) begin
                  seq_q <= MST_DONE;
               end
            end
            MST_DONE: begin
               if (start_p) begin
                  seq_q <= MST_MSEARCH;
               end else if (trace_mode == MST_CONTIN && !stop_p) begin
                  seq_q <= MST_MSEARCH;
               end
            end
            default: begin
               seq_q <= MST_IDLE;
            end
         endcase
      end
   end

   // search enables: slave held off until armed
   always_comb begin
      state_search_en = 1'b0;
      timing_search_en = 1'b0;
      if (seq_q == MST_MSEARCH) begin
         if (master == MST_STATE) begin
            state_search_en = 1'b1;
         end else begin
            timing_search_en = 1'b1;
         end
      end else if (seq_q == MST_ARMED) begin
         state_search_en = (master == MST_STATE) ? ~mtrig_q : ~strig_q;
         timing_search_en = (master == MST_STATE) ? ~strig_q : ~mtrig_q;
      end
   end

   // trigger and completion tracking, cleared at every new trace
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mtrig_q <= 1'b0;
         strig_q <= 1'b0;
         mdone_q <= 1'b0;
         sdone_q <= 1'b0;
      end else if ((seq_q == MST_IDLE && start_p) || (seq_q == MST_DONE &&
                   (start_p || (trace_mode == MST_CONTIN && !stop_p)))) begin
         // only where the sequencer really starts a new trace
         mtrig_q <= 1'b0;
         strig_q <= 1'b0;
         mdone_q <= 1'b0;
         sdone_q <= 1'b0;
      end else begin
         if (seq_q == MST_MSEARCH && master_hit) begin
            mtrig_q <= 1'b1;
            if (slave_freerun || slave_dontcare) begin
               strig_q <= 1'b1;
            end
         end
         if (seq_q == MST_ARMED && slave_hit) begin
            strig_q <= 1'b1;
         end
         if (seq_q == MST_ARMED && master_done) begin
            mdone_q <= 1'b1;
         end
         if (seq_q == MST_ARMED && slave_done && strig_q) begin
            sdone_q <= 1'b1;
         end
      end
   end

   // trigger store strobes; master store timed by its own delay logic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_store_q <= 1'b0;
         t_store_q <= 1'b0;
      end else begin
         s_store_q <= 1'b0;
         t_store_q <= 1'b0;
         if (seq_q == MST_MSEARCH && master_hit && (slave_freerun || slave_dontcare)) begin
            // slave stores at arming, ahead of a delayed master
            if (master == MST_STATE) begin
               t_store_q <= 1'b1;
            end else begin
               s_store_q <= 1'b1;
            end
         end else if (seq_q == MST_ARMED && slave_hit && !strig_q) begin
            if (master == MST_STATE) begin
               t_store_q <= 1'b1;
            end else begin
               s_store_q <= 1'b1;
            end
         end
      end
   end
   assign state_trig_store = s_store_q;
   assign timing_trig_store = t_store_q;

   // results release: both done, or stop with partial data
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         valid_q <= 1'b0;
         sok_q <= 1'b0;
         tok_q <= 1'b0;
      end else if (seq_q == MST_MSEARCH && !stop_p) begin
         valid_q <= 1'b0;
         sok_q <= 1'b0;
         tok_q <= 1'b0;
      end else if (seq_q == MST_ARMED && mdone_q && sdone_q) begin
         valid_q <= 1'b1;
         sok_q <= 1'b1;
         tok_q <= 1'b1;
      end else if ((seq_q == MST_ARMED || seq_q == MST_MSEARCH) && stop_p) begin
         valid_q <= 1'b1;
         sok_q <= (master == MST_STATE) ? mdone_q : sdone_q;
         tok_q <= (master == MST_STATE) ? sdone_q : mdone_q;
      end
   end
   assign results_valid = valid_q;
   assign state_data_ok = sok_q;
   assign timing_data_ok = tok_q;

   ////////////////////////////////////////////////////////////////////
   // probe split: timing pod, dropped lowest pod, state channels
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tprobe_q <= '0;
         sprobe_q <= '0;
      end else begin
         tprobe_q <= probe_in[PROBE_W-1 -: TIMING_CH];
         sprobe_q <= probe_in[POD_BITS +: STATE_CH];
      end
   end
   assign timing_probe = tprobe_q;
   assign state_probe = sprobe_q;

   ////////////////////////////////////////////////////////////////////
   // status and register reads
   always_comb begin
      status = '0;
      status[ST_BUSY] = (seq_q == MST_MSEARCH) || (seq_q == MST_ARMED);
      status[ST_ARMED] = (seq_q == MST_ARMED);
      status[ST_MDONE] = mdone_q;
      status[ST_SDONE] = sdone_q;
      status[ST_STATE_OK] = sok_q;
      status[ST_TIMING_OK] = tok_q;
      status[ST_RESULTS] = valid_q;
      status[ST_MTRIG] = mtrig_q;
      status[ST_STRIG] = strig_q;
      status[ST_OVERVIEW] = overview_en;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= '0;
      end else if (avs_read && !ack_q) begin
         case (avs_address)
            OFS_CTRL: rdata_q <= ctrl_q;
            OFS_STAT: rdata_q <= status;
            OFS_PROBE: rdata_q <= {{(32-TIMING_CH){1'b0}}, tprobe_q};
            OFS_CHANS: rdata_q <= {16'h0000, 8'(TIMING_CH), 8'(STATE_CH)};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // assertions
   a_slave_held_off: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_q == MST_MSEARCH) |-> ((master == MST_STATE) ? !timing_search_en : !state_search_en))
      else $error("slave searching before arming");
   a_master_arms_slave: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_q == MST_MSEARCH && master_hit && !stop_p) |=> (seq_q == MST_ARMED))
      else $error("master trigger did not arm slave");
   a_freerun_trig: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_q == MST_MSEARCH && master_hit && slave_freerun) |=> strig_q)
      else $error("free-running slave not triggered");
   a_dontcare_store: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_q == MST_MSEARCH && master_hit && slave_dontcare) |=>
      (state_trig_store || timing_trig_store))
      else $error("slave trigger not stored at arming");
   a_results_held: assert property (@(posedge clk) disable iff (!reset_n)
      (results_valid && state_data_ok && timing_data_ok) |-> $past(seq_q) != MST_IDLE)
      else $error("results released from idle");
   a_stop_partial: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_q == MST_ARMED && stop_p && !(mdone_q && sdone_q)) |=>
      (results_valid && !(state_data_ok && timing_data_ok)))
      else $error("stop did not mark incomplete data");
   a_no_overview: assert property (@(posedge clk) disable iff (!reset_n) !overview_en)
      else $error("overview enabled");
   a_new_trace_clear: assert property (@(posedge clk) disable iff (!reset_n)
      (seq_q == MST_DONE && start_p) |=> (!strig_q && !mtrig_q && seq_q == MST_MSEARCH))
      else $error("arming not cleared at new trace");
endmodule
`default_nettype wire

/* File: verilog/mst_pkg.sv */
// package of constants for the master/slave trigger arming block
package mst_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STAT = 4'h4;
   localparam logic [3:0] OFS_PROBE = 4'h8;
   localparam logic [3:0] OFS_CHANS = 4'hC;
   // control field positions
   localparam int CTRL_RUN = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_MASTER = 2;
   localparam int CTRL_MODE_LO = 3;
   localparam int CTRL_FREERUN = 5;
   localparam int CTRL_SDELAY0 = 6;
   // status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_ARMED = 1;
   localparam int ST_MDONE = 2;
   localparam int ST_SDONE = 3;
   localparam int ST_STATE_OK = 4;
   localparam int ST_TIMING_OK = 5;
   localparam int ST_RESULTS = 6;
   localparam int ST_MTRIG = 7;
   localparam int ST_STRIG = 8;
   localparam int ST_OVERVIEW = 9;
   // channel split
   localparam int TIMING_CH = 8;
   localparam int POD_BITS = 8;
   localparam int STATE_CH_SMALL = 27;
   localparam int STATE_CH_LARGE = 57;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // master selection
   typedef enum logic {
      MST_STATE = 1'b0,
      MST_TIMING = 1'b1
   } mst_master_t;
   // common trace mode
   typedef enum logic [1:0] {
      MST_SINGLE = 2'b00,
      MST_CONTIN = 2'b01,
      MST_COMPARE = 2'b10
   } mst_mode_t;
   // trace sequencer states
   typedef enum logic [1:0] {
      MST_IDLE = 2'b00,
      MST_MSEARCH = 2'b01,
      MST_ARMED = 2'b10,
      MST_DONE = 2'b11
   } mst_seq_t;
endpackage
